// ---- design/rtcwl_clock_source_select.v ----
// Reference clock selector: synchronises the slow source pins, picks one
// and turns its rising edges into one-cycle ticks; the system clock code ticks every enabled cycle.
// Assumes source pins are asynchronous to sys_clk and far slower than it.
`include "rtcwl_defs.vh"

module rtcwl_clock_source_select (
    input wire sys_clk,
    input wire arst_n,
    input wire clk_en,
    input wire [1:0] clk_sel,
    input wire secondary_oscillator_in,
    input wire low_power_rc_osc_in,
    input wire pwrline_in,
    output wire ref_tick
);

    reg [2:0] meta_q;
    reg [2:0] sync_q;
    reg prev_q;
    reg sel_lvl;

    // Two flops per pin; the first is read only by the second
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
            prev_q <= 1'b0;
        end else if (clk_en) begin
            meta_q <= {pwrline_in, low_power_rc_osc_in, secondary_oscillator_in};
            sync_q <= meta_q;
            prev_q <= sel_lvl;
        end
    end

    // Source choice from the select field
    always @* begin
        case (clk_sel)
            `RTCWL_SRC_SECONDARY_OSCILLATOR: sel_lvl = sync_q[0];
            `RTCWL_SRC_LOW_POWER_RC_OSC: sel_lvl = sync_q[1];
            `RTCWL_SRC_PWRLINE: sel_lvl = sync_q[2];
            default: sel_lvl = 1'b0;
        endcase
    end

    // System clock source ticks every enabled cycle
    assign ref_tick = clk_en && ((clk_sel == `RTCWL_SRC_SYSCLK) || (sel_lvl && !prev_q));

endmodule // rtcwl_clock_source_select

// ---- design/rtcwl_top.v ----
// Calendar register file with write lock, key unlock and reference clock select.
// Assumes a same-clock bus master and a synchronous device reset request.
//
// The address map and the strobed register port were chosen for this implementation.
`include "rtcwl_defs.vh"

module rtcwl_top #(
    parameter WIN_CYC = `RTCWL_UNLOCK_WIN_CYC
) (
    input wire sys_clk,
    input wire arst_n,
    input wire clk_en,
    input wire dev_reset,
    input wire [`RTCWL_ADDR_W-1:0] bus_addr,
    input wire [`RTCWL_DATA_W-1:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [`RTCWL_DATA_W-1:0] bus_rdata,
    input wire secondary_oscillator_in,
    input wire low_power_rc_osc_in,
    input wire pwrline_in,
    output wire ref_tick,
    output wire [1:0] clk_sel,
    output wire cal_enable,
    output wire write_lock
);

    // ********************************************************************
    // Storage
    // ********************************************************************
    // Register map by word index
    // 0: control one
    //   15: calendar enable, locked
    //   14-12: read zero
    //   11: write lock
    //   10-0: free bits, never locked

    // 1: control two, locked
    //   15-2: plain storage
    //   1-0: reference select, on clk_sel
    //     00 secondary oscillator
    //     01 low-power RC
    //     10 powerline, 50 or 60 Hz
    //     11 system clock

    // 2, 3: time low, high, locked
    // 4, 5: date low, high, locked
    // 6: alarm time, never locked
    // 7: alarm date, never locked

    // 8: timestamp date high
    //   15-12: year tens, BCD
    //   11-8: year units, BCD
    //   7-5: zero while timestamps run
    //   4: month tens, 0 or 1
    //   3-0: month units, 0 to 9
    //   All 16 bits kept while off

    // 9: timestamp control
    //   0: timestamp enable
    //   15-1: read zero

    // 10: key, write-only, reads zero
    //   7-0: 55h then AAh
    //   15-8: ignored

    // 11: status, read-only
    //   15-8: reference tick count
    //   7-2: read zero
    //   1: clear window open
    //   0: write lock

    // 12 to 15: read zero

    // Resets
    //   arst_n is power-on, clears every flop
    //   Reset values are all zero
    //   Device reset clears lock and key state
    //   Key state: idle, armed, open
    //   Values, alarms, timestamp survive it
    //   clk_en low holds a device reset off

    // Timing
    //   Writes land at the strobe edge
    //   Read data stand one cycle, then zero
    //   Window opens the cycle after AAh
    //   It lasts WIN_CYC cycles or one write
    //   A read inside the sequence is harmless
    //   Any other write aborts the sequence
    //   Lock clear takes bit 11 and free bits 10-0
    //   Bit 15 in that write is dropped
    //   Source pins lag two to three cycles
    //   Ticks count only with the calendar on

    // Limitations
    //   No calendar counting or alarm match
    //   No timestamp capture
    //   Tick count wraps; a sign of life only
    //   ref_tick is combinational
    //   A select change may give a stray tick
    //   Locking first keeps the calendar off,
    //   so set the enable with the lock

    // Register state
    reg write_lock_bit_q;
    reg calendar_enable_q;
    reg [10:0] ctrl1_free_q;
    reg [15:0] control_reg_two_q;
    reg [15:0] time_lo_q;
    reg [15:0] time_hi_q;
    reg [15:0] date_lo_q;
    reg [15:0] date_hi_q;
    reg [15:0] alm_time_q;
    reg [15:0] alm_date_q;
    reg [15:0] timestamp_a_date_high_q;
    reg timestamp_a_enable_q;
    reg [7:0] tick_cnt_q;
    reg [15:0] rdata_d;
    wire win_open;
    wire key_wr;
    wire other_wr;
    wire lock_ok;
    wire [15:0] ts_read;

    // Address match used by every write decode
    function wr_hit;
        input [`RTCWL_ADDR_W-1:0] a;
        input [`RTCWL_ADDR_W-1:0] r;
        input w;
        begin
            wr_hit = w && (a == r);
        end
    endfunction

    // Gap bits of the timestamp word only matter while timestamps run
    function [15:0] ts_view;
        input [15:0] w;
        input en;
        begin
            ts_view = en ? (w & `RTCWL_TS_DATE_MASK) : w;
        end
    endfunction

    // ********************************************************************
    // Key sequencer and source select
    // ********************************************************************
    assign key_wr = wr_hit(bus_addr, `RTCWL_REG_KEY, bus_wr);
    assign other_wr = bus_wr && !key_wr;

    rtcwl_unlock #(
        .WIN_CYC(WIN_CYC)
    ) u_unlock (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .dev_reset(dev_reset),
        .key_wr(key_wr),
        .key_byte(bus_wdata[7:0]),
        .other_wr(other_wr),
        .win_open(win_open)
    );

    rtcwl_clock_source_select u_clock_source_select (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .clk_sel(control_reg_two_q[1:0]),
        .secondary_oscillator_in(secondary_oscillator_in),
        .low_power_rc_osc_in(low_power_rc_osc_in),
        .pwrline_in(pwrline_in),
        .ref_tick(ref_tick)
    );

    // Locked fields take writes only while the lock reads zero this cycle
    assign lock_ok = !write_lock_bit_q;

    assign clk_sel = control_reg_two_q[1:0];
    assign cal_enable = calendar_enable_q;
    assign write_lock = write_lock_bit_q;
    assign ts_read = ts_view(timestamp_a_date_high_q, timestamp_a_enable_q);

    // ********************************************************************
    // Lock bit
    // ********************************************************************
    // Device reset is synchronous; power-on reset is the async input
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            write_lock_bit_q <= 1'b0;
        end else if (clk_en) begin
            if (dev_reset) begin
                write_lock_bit_q <= 1'b0;
            end else if (wr_hit(bus_addr, `RTCWL_REG_CTRL1, bus_wr)) begin
                if (!write_lock_bit_q) begin
                    write_lock_bit_q <= bus_wdata[`RTCWL_LOCK_BIT];
                end else if (win_open) begin
                    write_lock_bit_q <= bus_wdata[`RTCWL_LOCK_BIT];
                end
            end
        end
    end

    // ********************************************************************
    // Locked control and value registers
    // ********************************************************************
    // Cleared at power-on only, so a locked calendar keeps running
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            calendar_enable_q <= 1'b0;
            control_reg_two_q <= `RTCWL_RST_WORD;
            time_lo_q <= `RTCWL_RST_WORD;
            time_hi_q <= `RTCWL_RST_WORD;
            date_lo_q <= `RTCWL_RST_WORD;
            date_hi_q <= `RTCWL_RST_WORD;
        end else if (clk_en && lock_ok) begin
            if (wr_hit(bus_addr, `RTCWL_REG_CTRL1, bus_wr)) begin
                calendar_enable_q <= bus_wdata[`RTCWL_CAL_EN_BIT];
            end
            if (wr_hit(bus_addr, `RTCWL_REG_CTRL2, bus_wr)) begin
                control_reg_two_q <= bus_wdata;
            end
            if (wr_hit(bus_addr, `RTCWL_REG_TIME_LO, bus_wr)) begin
                time_lo_q <= bus_wdata;
            end
            if (wr_hit(bus_addr, `RTCWL_REG_TIME_HI, bus_wr)) begin
                time_hi_q <= bus_wdata;
            end
            if (wr_hit(bus_addr, `RTCWL_REG_DATE_LO, bus_wr)) begin
                date_lo_q <= bus_wdata;
            end
            if (wr_hit(bus_addr, `RTCWL_REG_DATE_HI, bus_wr)) begin
                date_hi_q <= bus_wdata;
            end
        end
    end

    // ********************************************************************
    // Always-writable registers
    // ********************************************************************
    // Timestamp word resets only at power-on, so it doubles as scratch
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl1_free_q <= 11'h000;
            alm_time_q <= `RTCWL_RST_WORD;
            alm_date_q <= `RTCWL_RST_WORD;
            timestamp_a_date_high_q <= `RTCWL_RST_WORD;
            timestamp_a_enable_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_hit(bus_addr, `RTCWL_REG_CTRL1, bus_wr)) begin
                ctrl1_free_q <= bus_wdata[10:0];
            end
            if (wr_hit(bus_addr, `RTCWL_REG_ALM_TIME, bus_wr)) begin
                alm_time_q <= bus_wdata;
            end
            if (wr_hit(bus_addr, `RTCWL_REG_ALM_DATE, bus_wr)) begin
                alm_date_q <= bus_wdata;
            end
            if (wr_hit(bus_addr, `RTCWL_REG_TS_DATE_HI, bus_wr)) begin
                // Plain storage keeps all 16 bits while timestamps are off
                timestamp_a_date_high_q <= ts_view(bus_wdata, timestamp_a_enable_q);
            end
            if (wr_hit(bus_addr, `RTCWL_REG_TS_CTRL, bus_wr)) begin
                timestamp_a_enable_q <= bus_wdata[`RTCWL_TS_EN_BIT];
            end
        end
    end

    // ********************************************************************
    // Reference tick counter
    // ********************************************************************
    // Counts ticks only with the calendar on, wraps; lets software see the chosen source is alive
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_q <= 8'h00;
        end else if (clk_en && ref_tick && calendar_enable_q) begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
        end
    end

    // ********************************************************************
    // Read path
    // ********************************************************************
    // Read mux; unmapped and key addresses read zero
    always @* begin
        case (bus_addr)
            `RTCWL_REG_CTRL1: rdata_d = {calendar_enable_q, 3'h0, write_lock_bit_q, ctrl1_free_q};
            `RTCWL_REG_CTRL2: rdata_d = control_reg_two_q;
            `RTCWL_REG_TIME_LO: rdata_d = time_lo_q;
            `RTCWL_REG_TIME_HI: rdata_d = time_hi_q;
            `RTCWL_REG_DATE_LO: rdata_d = date_lo_q;
            `RTCWL_REG_DATE_HI: rdata_d = date_hi_q;
            `RTCWL_REG_ALM_TIME: rdata_d = alm_time_q;
            `RTCWL_REG_ALM_DATE: rdata_d = alm_date_q;
            `RTCWL_REG_TS_DATE_HI: rdata_d = ts_read;
            `RTCWL_REG_TS_CTRL: rdata_d = {15'h0000, timestamp_a_enable_q};
            `RTCWL_REG_STATUS: rdata_d = {tick_cnt_q, 6'h00, win_open, write_lock_bit_q};
            default: rdata_d = 16'h0000;
        endcase
    end

    // Data stand for the one cycle after the read strobe only
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= 16'h0000;
        end else if (clk_en) begin
            bus_rdata <= bus_rd ? rdata_d : 16'h0000;
        end
    end

endmodule // rtcwl_top

// ---- design/rtcwl_unlock.v ----
// Key sequencer: watches key writes and opens a short window for lock clearing.
// Assumes bus strobes from the same clock domain, one cycle each.
`include "rtcwl_defs.vh"

module rtcwl_unlock #(
    parameter WIN_CYC = `RTCWL_UNLOCK_WIN_CYC
) (
    input wire sys_clk,
    input wire arst_n,
    input wire clk_en,
    input wire dev_reset,
    input wire key_wr,
    input wire [7:0] key_byte,
    input wire other_wr,
    output wire win_open
);

    // ********************************************************************
    // Sequence states
    // ********************************************************************
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ARMED = 2'h1;
    localparam [1:0] ST_OPEN = 2'h2;
    localparam [7:0] WIN_LEN = (WIN_CYC < 1) ? 8'h01 : WIN_CYC[7:0];

    reg [1:0] st_q;
    reg [1:0] st_d;
    reg [7:0] cnt_q;
    reg [7:0] cnt_d;

    assign win_open = (st_q == ST_OPEN);

    // Any write other than the expected key byte aborts the sequence
    always @* begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            ST_IDLE: begin
                if (key_wr && key_byte == `RTCWL_KEY_FIRST) begin
                    st_d = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (key_wr && key_byte == `RTCWL_KEY_SECOND) begin
                    st_d = ST_OPEN;
                    cnt_d = WIN_LEN;
                end else if (key_wr || other_wr) begin
                    st_d = ST_IDLE;
                end
            end
            ST_OPEN: begin
                // One write or the end of the window closes it
                if (key_wr || other_wr || cnt_q == 8'h01) begin
                    st_d = ST_IDLE;
                    cnt_d = 8'h00;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: begin
                st_d = ST_IDLE;
                cnt_d = 8'h00;
            end
        endcase
    end

    // State register; a device reset drops any half-done sequence
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_IDLE;
            cnt_q <= 8'h00;
        end else if (clk_en) begin
            if (dev_reset) begin
                st_q <= ST_IDLE;
                cnt_q <= 8'h00;
            end else begin
                st_q <= st_d;
                cnt_q <= cnt_d;
            end
        end
    end

endmodule // rtcwl_unlock

// ---- shared/rtcwl_defs.vh ----
// Constants for the calendar write-lock, key unlock and clock-select block.
// Assumes one 50 MHz clock domain and a plain word-indexed register port.
`ifndef RTCWL_DEFS_VH
`define RTCWL_DEFS_VH

// ********************************************************************
// Register indices
// ********************************************************************
`define RTCWL_ADDR_W 4
`define RTCWL_DATA_W 16
`define RTCWL_REG_CTRL1 4'h0
`define RTCWL_REG_CTRL2 4'h1
`define RTCWL_REG_TIME_LO 4'h2
`define RTCWL_REG_TIME_HI 4'h3
`define RTCWL_REG_DATE_LO 4'h4
`define RTCWL_REG_DATE_HI 4'h5
`define RTCWL_REG_ALM_TIME 4'h6
`define RTCWL_REG_ALM_DATE 4'h7
`define RTCWL_REG_TS_DATE_HI 4'h8
`define RTCWL_REG_TS_CTRL 4'h9
`define RTCWL_REG_KEY 4'hA
`define RTCWL_REG_STATUS 4'hB

// ********************************************************************
// Field positions and masks
// ********************************************************************
`define RTCWL_CAL_EN_BIT 15
`define RTCWL_LOCK_BIT 11
`define RTCWL_CTRL1_FREE_MASK 16'h07FF
`define RTCWL_TS_DATE_MASK 16'hFF1F
`define RTCWL_TS_EN_BIT 0
`define RTCWL_ST_LOCK_BIT 0
`define RTCWL_ST_WIN_BIT 1
`define RTCWL_KEY_FIRST 8'h55
`define RTCWL_KEY_SECOND 8'hAA

// ********************************************************************
// Clock source codes
// ********************************************************************
`define RTCWL_SRC_SECONDARY_OSCILLATOR 2'h0
`define RTCWL_SRC_LOW_POWER_RC_OSC 2'h1
`define RTCWL_SRC_PWRLINE 2'h2
`define RTCWL_SRC_SYSCLK 2'h3

// ********************************************************************
// Reset values and timing
// ********************************************************************
`define RTCWL_RST_WORD 16'h0000
`define RTCWL_CLK_MHZ 50
`define RTCWL_INSTR_NS 40
`define RTCWL_UNLOCK_WIN_CYC ((`RTCWL_INSTR_NS * `RTCWL_CLK_MHZ) / 1000)

`endif

// ---- verification/rtcwl_properties.sv ----
// Port checker for the calendar write-lock and clock-select block.
// Assumes it is bound to rtcwl_top and shares its single clock.
`include "rtcwl_defs.vh"

module rtcwl_properties #(
    parameter WIN_CYC = 2
) (
    input wire sys_clk,
    input wire arst_n,
    input wire clk_en,
    input wire dev_reset,
    input wire [`RTCWL_ADDR_W-1:0] bus_addr,
    input wire [`RTCWL_DATA_W-1:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    input wire [`RTCWL_DATA_W-1:0] bus_rdata,
    input wire secondary_oscillator_in,
    input wire low_power_rc_osc_in,
    input wire pwrline_in,
    input wire ref_tick,
    input wire [1:0] clk_sel,
    input wire cal_enable,
    input wire write_lock
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Helper logic
    // ****************************************
    reg [1:0] key_age_q;
    reg ts_en_q;
    wire key_wr = clk_en && bus_wr && bus_addr == `RTCWL_REG_KEY;
    wire wr_c1 = clk_en && bus_wr && bus_addr == `RTCWL_REG_CTRL1;
    wire wr_c2 = clk_en && bus_wr && bus_addr == `RTCWL_REG_CTRL2;

    // Age of the last key write; saturates so old keys never open the lock
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            key_age_q <= 2'h3;
        else if (key_wr)
            key_age_q <= 2'h0;
        else if (clk_en && key_age_q != 2'h3)
            key_age_q <= key_age_q + 2'h1;
    end

    // Timestamp enable as last written; gap bits read zero only while set
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            ts_en_q <= 1'b0;
        else if (clk_en && bus_wr && bus_addr == `RTCWL_REG_TS_CTRL)
            ts_en_q <= bus_wdata[`RTCWL_TS_EN_BIT];
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // ****************************************
    // Sequences and properties
    // ****************************************
    sequence s_key_pair;
        key_wr && bus_wdata[7:0] == `RTCWL_KEY_FIRST ##1 key_wr && bus_wdata[7:0] == `RTCWL_KEY_SECOND;
    endsequence
    sequence s_clear_wr;
        wr_c1 && !bus_wdata[`RTCWL_LOCK_BIT] && !dev_reset;
    endsequence

    a_key_unlock: assert property (s_key_pair ##1 s_clear_wr |=> !write_lock)
        else $error("lock kept after key pair and clear");
    a_lock_fall: assert property ($fell(write_lock) |->
        $past(dev_reset && clk_en) || key_age_q <= WIN_CYC)
        else $error("lock dropped without key or reset");
    a_lock_set: assert property (!write_lock && wr_c1 && bus_wdata[11] && !dev_reset
        |=> write_lock)
        else $error("plain lock write not taken");
    a_dev_clear: assert property (clk_en && dev_reset |=> !write_lock)
        else $error("device reset left lock set");
    a_cal_frozen: assert property (write_lock |=> $stable(cal_enable))
        else $error("calendar enable changed while locked");
    a_sel_frozen: assert property (write_lock |=> $stable(clk_sel))
        else $error("clock select changed while locked");
    a_sel_write: assert property (!write_lock && wr_c2 |=> clk_sel == $past(bus_wdata[1:0]))
        else $error("clock select write lost");
    a_cal_write: assert property (!write_lock && wr_c1 |=> cal_enable == $past(bus_wdata[15]))
        else $error("calendar enable write lost");
    a_ts_gap: assert property (clk_en && bus_rd && bus_addr == `RTCWL_REG_TS_DATE_HI
        && ts_en_q |=> bus_rdata[7:5] == 3'h0)
        else $error("timestamp gap bits not zero");
    a_sys_tick: assert property (clk_en && clk_sel == 2'h3 && $past(clk_sel) == 2'h3
        |-> ref_tick)
        else $error("system clock source gave no tick");
endmodule // rtcwl_properties

// ---- verification/rtcwl_top_tb_top.sv ----
// Self-checking bench for the calendar write-lock and clock-select block.
// Assumes rtcwl_defs.vh on the include path and the checker compiled first.
`include "rtcwl_defs.vh"

module rtcwl_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WIN = 2;
    logic sys_clk, arst_n, clk_en, dev_reset, bus_wr, bus_rd, rd_q;
    logic secondary_oscillator_in, low_power_rc_osc_in, pwrline_in;
    logic [3:0] bus_addr;
    logic [15:0] bus_wdata, rnd, cnt;
    logic [15:0] mem [0:9];
    logic [15:0] exp_q [$];
    logic [31:0] seed = 32'hFB8B7E43;
    wire [15:0] bus_rdata;
    wire [1:0] clk_sel;
    wire ref_tick, cal_enable, write_lock;
    int miscompares = 0;
    int compares = 0;

    rtcwl_top #(.WIN_CYC(WIN)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
        .dev_reset(dev_reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .secondary_oscillator_in(secondary_oscillator_in), .low_power_rc_osc_in(low_power_rc_osc_in),
        .pwrline_in(pwrline_in), .ref_tick(ref_tick), .clk_sel(clk_sel),
        .cal_enable(cal_enable), .write_lock(write_lock));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_rd(input logic [15:0] e);
        chk("read data", e, bus_rdata);
    endtask
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Bus ops own one cycle each, so back-to-back calls never double-drive
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_rd <= 1'b0;
        bus_addr <= a;
        bus_wdata <= d;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        exp_q.push_back(e);
        bus_rd <= 1'b1;
        bus_wr <= 1'b0;
        bus_addr <= a;
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            bus_wr <= 1'b0;
            bus_rd <= 1'b0;
            bus_wdata <= nxt();
        end
    endtask
    task automatic settle();
        idle(1);
        @(negedge sys_clk);
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
    endtask
    task automatic ticks(input int n);
        cnt = 16'h0000;
        repeat (n) begin
            @(negedge sys_clk);
            cnt = cnt + {15'h0000, ref_tick};
        end
    endtask
    task automatic check_regs(input int n, input logic zero);
        for (int a = 0; a < n; a++)
            rd(a[3:0], zero ? 16'h0000 : mem[a]);
    endtask
    // Key pair, optional gap, then a clear attempt; relocks afterwards
    task automatic try_key(input logic [7:0] k1, input logic [7:0] k2, input int gap,
                           input logic e);
        wr(`RTCWL_REG_KEY, {8'h00, k1});
        wr(`RTCWL_REG_KEY, {8'h00, k2});
        idle(gap);
        wr(`RTCWL_REG_CTRL1, 16'h8000);
        settle();
        chk("lock", {15'h0000, e}, {15'h0000, write_lock});
        wr(`RTCWL_REG_CTRL1, 16'h8800);
    endtask

    // ****************************************
    // Clock, monitor, watchdog
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Read data stands only in the cycle after the strobe, so look there
    always @(posedge sys_clk) rd_q <= bus_rd && clk_en;
    always @(negedge sys_clk) begin
        if (rd_q)
            chk_rd(exp_q.pop_front());
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        print_verdict();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        dev_reset = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 4'h0;
        bus_wdata = 16'h0000;
        {pwrline_in, low_power_rc_osc_in, secondary_oscillator_in} = 3'b000;
        do_reset();
        check_regs(16, 1'b1);
        // Unlocked: every value, alarm and timestamp word is writable
        for (int a = 1; a < 9; a++) begin
            rnd = nxt();
            mem[a] = rnd;
            wr(a[3:0], rnd);
            rd(a[3:0], mem[a]);
        end
        // Each source: unselected edges give nothing, the chosen one ticks
        for (int c = 0; c < 4; c++) begin
            wr(`RTCWL_REG_CTRL2, {14'h0000, c[1:0]});
            settle();
            chk("clk_sel", {14'h0000, c[1:0]}, {14'h0000, clk_sel});
            {pwrline_in, low_power_rc_osc_in, secondary_oscillator_in} <= 3'b000;
            ticks(6);
            @(posedge sys_clk);
            {pwrline_in, low_power_rc_osc_in, secondary_oscillator_in} <= ~(3'b001 << c);
            ticks(8);
            chk("ticks idle", (c == 3) ? 16'h0008 : 16'h0000, cnt);
            @(posedge sys_clk);
            {pwrline_in, low_power_rc_osc_in, secondary_oscillator_in} <= 3'b111;
            ticks(8);
            chk("ticks edge", (c == 3) ? 16'h0008 : 16'h0001, cnt);
        end
        mem[1] = 16'h0003;
        wr(`RTCWL_REG_CTRL1, 16'h8000);
        wr(`RTCWL_REG_CTRL1, 16'h8800);
        settle();
        chk("lock", 16'h0001, {15'h0000, write_lock});
        chk("cal", 16'h0001, {15'h0000, cal_enable});
        // Locked: values and select dropped, alarms, timestamp, free bits kept
        for (int a = 0; a < 9; a++) begin
            rnd = nxt();
            wr(a[3:0], rnd);
            if (a == 0)
                mem[0] = 16'h8800 | (rnd & `RTCWL_CTRL1_FREE_MASK);
            else if (a > 5)
                mem[a] = rnd;
        end
        check_regs(9, 1'b0);
        // Timestamps on: gap bits read zero yet stay stored
        mem[8] = nxt() | 16'h00E0;
        wr(`RTCWL_REG_TS_DATE_HI, mem[8]);
        wr(`RTCWL_REG_TS_CTRL, 16'h0001);
        rd(`RTCWL_REG_TS_DATE_HI, mem[8] & `RTCWL_TS_DATE_MASK);
        wr(`RTCWL_REG_TS_CTRL, 16'h0000);
        rd(`RTCWL_REG_TS_DATE_HI, mem[8]);
        try_key(8'h55, 8'hAA, WIN, 1'b1);
        try_key(8'hAA, 8'h55, 0, 1'b1);
        try_key(8'h55, 8'h55, 0, 1'b1);
        try_key(8'h55, 8'hAA, WIN - 1, 1'b0);
        try_key(8'h55, 8'hAA, 0, 1'b0);
        // Device reset is ignored while frozen, then clears only the lock
        idle(1);
        clk_en <= 1'b0;
        dev_reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("frozen lock", 16'h0001, {15'h0000, write_lock});
        clk_en <= 1'b1;
        @(posedge sys_clk);
        dev_reset <= 1'b0;
        @(negedge sys_clk);
        chk("lock", 16'h0000, {15'h0000, write_lock});
        mem[0] = 16'h8000; // Key tries left the free bits zero
        check_regs(9, 1'b0);
        idle(2);
        do_reset();
        check_regs(9, 1'b1);
        idle(3);
        chk("pending reads", 16'h0000, 16'(exp_q.size()));
        print_verdict();
    end
endmodule // rtcwl_top_tb_top

bind rtcwl_top rtcwl_properties #(.WIN_CYC(WIN_CYC)) i_props (.sys_clk(sys_clk),
    .arst_n(arst_n), .clk_en(clk_en), .dev_reset(dev_reset), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .secondary_oscillator_in(secondary_oscillator_in), .low_power_rc_osc_in(low_power_rc_osc_in), .pwrline_in(pwrline_in), .ref_tick(ref_tick),
    .clk_sel(clk_sel), .cal_enable(cal_enable), .write_lock(write_lock));
